// ### hw/goc_pkg.sv
package goc_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CTRL2_OFS = 8'h04;
	localparam logic [7:0] TRIMP_OFS = 8'h08;
	localparam logic [7:0] TRIMN_OFS = 8'h0c;
	localparam logic [7:0] RESULT_OFS = 8'h10;
	localparam logic [7:0] DELAY1_OFS = 8'h14;
	localparam logic [7:0] DELAY2_OFS = 8'h18;
	// converter_control fields
	localparam int CTRL_SAMPLE_BIT = 0;
	localparam int CTRL_TRIG_BIT = 1;
	localparam int CTRL_REG_EN_BIT = 2;
	localparam int CTRL_SE_BIT = 3;
	localparam int CTRL_MUTE_BIT = 4;
	localparam int CTRL_SIGN_BIT = 5;
	localparam int CTRL_CHOP_BIT = 6;
	localparam int CTRL_CHAN_LSB = 8;
	localparam int CTRL_CHAN_W = 3;
	// converter_control_second fields
	localparam int CTRL2_ATTN_BIT = 0;
	localparam int CTRL2_DELAY_EN_BIT = 1;
	// Channel that routes the battery monitor
	localparam logic [2:0] CHAN_BATTERY = 3'h4;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
	localparam logic [9:0] TRIM_RST = 10'h200;
	localparam logic [9:0] MID_LOW = 10'h1ff;
	localparam logic [9:0] MID_HIGH = 10'h200;
	// delay_timing_first: [7:0] regulator delay, [15:8] trigger delay
	// delay_timing_second: [7:0] sampling delay; unit is 1/8 us
	localparam logic [15:0] DELAY1_RST = 16'h1000;
	localparam logic [7:0] DELAY2_RST = 8'h08;
	localparam int DELAY_STEP_NS = 125;
	// Timing
	localparam int CLK_NS = 25;
	localparam int DELAY_STEP_CYC = (DELAY_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLK_PS = CLK_NS * 1000;
	localparam int CONV_PS = 62500;
	localparam int CONV_CYC = (CONV_PS + CLK_PS - 1) / CLK_PS;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [31:0] READ_DEFAULT = 32'h0000_0000;
endpackage

// ### hw/goc_converter_control.sv
`timescale 1ns/1ps
module goc_converter_control (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [9:0] rawCode,
	output logic regulatorEnable,
	output logic samplingEnable,
	output logic convertStrobe,
	output logic inputCenterMute,
	output logic polarityInvert,
	output logic tripleRangeAttenuator,
	output logic singleEndedSelect,
	output logic [2:0] channelSelect,
	output logic [9:0] positiveOffsetTrim,
	output logic [9:0] negativeOffsetTrim
);
	typedef enum {ST_IDLE, ST_WAIT, ST_SETTLE, ST_CONV, ST_CHOP} goc_state_t;

	logic [31:0] ctrl_reg, ctrl_next;
	logic [1:0] ctrl2_reg, ctrl2_next;
	logic [9:0] trimP_reg, trimP_next, trimN_reg, trimN_next;
	logic [9:0] result_reg, result_next;
	logic [15:0] delay1_reg, delay1_next;
	logic [7:0] delay2_reg, delay2_next;
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next;
	logic [3:0] wStrb_reg, wStrb_next;
	logic bValid_reg, bValid_next, rValid_reg, rValid_next;
	logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;
	logic [31:0] rData_reg, rData_next;
	goc_state_t state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [11:0] dly_reg, dly_next;
	logic dlyRun_reg, dlyRun_next;
	logic [9:0] first_reg, first_next;
	logic [2:0] lastChan_reg, lastChan_next;
	logic strobe_reg, strobe_next;
	logic regOut_reg, regOut_next, sampOut_reg, sampOut_next;
	logic invOut_reg, invOut_next;
	logic attn_reg, attn_next;
	logic awReady_reg, awReady_next, wReady_reg, wReady_next, arReady_reg, arReady_next;

	logic doWrite, trigWrite, attnOn, chanChange;
	logic [31:0] merged;
	logic [10:0] chopSum;
	logic [9:0] signedCode;

	assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
	assign attnOn = ctrl2_reg[goc_pkg::CTRL2_ATTN_BIT]
		|| (ctrl_reg[goc_pkg::CTRL_CHAN_LSB +: goc_pkg::CTRL_CHAN_W] == goc_pkg::CHAN_BATTERY);
	assign chanChange = ctrl_reg[goc_pkg::CTRL_CHAN_LSB +: goc_pkg::CTRL_CHAN_W] != lastChan_reg;
	// Registered from next values so outputs line up with the registers behind them
	assign attn_next = ctrl2_next[goc_pkg::CTRL2_ATTN_BIT]
		|| (ctrl_next[goc_pkg::CTRL_CHAN_LSB +: goc_pkg::CTRL_CHAN_W] == goc_pkg::CHAN_BATTERY);
	assign awReady_next = !awHeld_next;
	assign wReady_next = !wHeld_next;
	assign arReady_next = !rValid_next;
	// Output sign flip restores orientation of an inverted sample
	assign signedCode = invOut_reg ? ~rawCode : rawCode;
	// Sum of two opposite samples cancels offset; LSB dropped to 10 bits
	assign chopSum = {1'b0, first_reg} + {1'b0, signedCode};

	always_comb begin
		merged = ctrl_reg;
		for (int i = 0; i < 4; i++) begin
			if (wStrb_reg[i]) begin
				merged[i*8 +: 8] = wData_reg[i*8 +: 8];
			end
		end
	end

	assign trigWrite = doWrite && awAddr_reg == goc_pkg::CTRL_OFS
		&& merged[goc_pkg::CTRL_TRIG_BIT] && !ctrl_reg[goc_pkg::CTRL_TRIG_BIT];

	// Bus slave
	always_comb begin
		awHeld_next = awHeld_reg;
		wHeld_next = wHeld_reg;
		awAddr_next = awAddr_reg;
		wData_next = wData_reg;
		wStrb_next = wStrb_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		rValid_next = rValid_reg;
		rResp_next = rResp_reg;
		rData_next = rData_reg;
		if (s_axi_awvalid && !awHeld_reg) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_reg) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
		end
		if (doWrite) begin
			bValid_next = 1'b1;
			bResp_next = (awAddr_reg <= goc_pkg::DELAY2_OFS && awAddr_reg[1:0] == 2'b00
				&& awAddr_reg != goc_pkg::RESULT_OFS) ? goc_pkg::RESP_OKAY : goc_pkg::RESP_SLVERR;
		end
		if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
		end
		if (s_axi_arvalid && !rValid_reg) begin
			rValid_next = 1'b1;
			rResp_next = goc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				goc_pkg::CTRL_OFS: rData_next = ctrl_reg;
				goc_pkg::CTRL2_OFS: rData_next = {30'h0, ctrl2_reg};
				goc_pkg::TRIMP_OFS: rData_next = {22'h0, trimP_reg};
				goc_pkg::TRIMN_OFS: rData_next = {22'h0, trimN_reg};
				goc_pkg::RESULT_OFS: rData_next = {22'h0, result_reg};
				goc_pkg::DELAY1_OFS: rData_next = {16'h0, delay1_reg};
				goc_pkg::DELAY2_OFS: rData_next = {24'h0, delay2_reg};
				default: begin
					rData_next = goc_pkg::READ_DEFAULT;
					rResp_next = goc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
		end
	end

	// Register file and conversion sequencer
	always_comb begin
		ctrl_next = ctrl_reg;
		ctrl2_next = ctrl2_reg;
		trimP_next = trimP_reg;
		trimN_next = trimN_reg;
		delay1_next = delay1_reg;
		delay2_next = delay2_reg;
		result_next = result_reg;
		state_next = state_reg;
		cnt_next = cnt_reg;
		dly_next = dly_reg;
		dlyRun_next = dlyRun_reg;
		first_next = first_reg;
		strobe_next = 1'b0;
		lastChan_next = ctrl_reg[goc_pkg::CTRL_CHAN_LSB +: goc_pkg::CTRL_CHAN_W];
		invOut_next = invOut_reg;
		if (doWrite) begin
			case (awAddr_reg)
				goc_pkg::CTRL_OFS: ctrl_next = merged;
				goc_pkg::CTRL2_OFS: if (wStrb_reg[0]) ctrl2_next = wData_reg[1:0];
				goc_pkg::TRIMP_OFS: trimP_next = wData_reg[9:0];
				goc_pkg::TRIMN_OFS: trimN_next = wData_reg[9:0];
				goc_pkg::DELAY1_OFS: delay1_next = wData_reg[15:0];
				goc_pkg::DELAY2_OFS: delay2_next = wData_reg[7:0];
				default: ;
			endcase
		end
		if (!ctrl2_next[goc_pkg::CTRL2_DELAY_EN_BIT]) begin
			dly_next = 12'h000;
			dlyRun_next = 1'b0;
		end else if (trigWrite) begin
			dlyRun_next = 1'b1;
		end else if (dlyRun_reg && dly_reg != 12'hfff) begin
			dly_next = dly_reg + 12'h001;
		end
		if (chanChange && state_reg == ST_SETTLE) begin
			cnt_next = 16'h0000;
		end
		case (state_reg)
			ST_IDLE: begin
				// Next value, so a sign written with the trigger applies to that conversion
				invOut_next = ctrl_next[goc_pkg::CTRL_SIGN_BIT];
				if (trigWrite) begin
					state_next = ST_WAIT;
					cnt_next = 16'h0000;
				end
			end
			ST_WAIT: begin
				// Trigger is held off by its programmed delay when delay counting is on
				if (!ctrl2_reg[goc_pkg::CTRL2_DELAY_EN_BIT]
					|| dly_reg >= 12'(delay1_reg[15:8]) * 12'(goc_pkg::DELAY_STEP_CYC)) begin
					state_next = attnOn ? ST_SETTLE : ST_CONV;
					cnt_next = 16'h0000;
				end
			end
			ST_SETTLE: begin
				if (!chanChange) begin
					cnt_next = cnt_reg + 16'h0001;
				end
				if (cnt_reg >= 16'(goc_pkg::SETTLE_CYC - 1)) begin
					state_next = ST_CONV;
					cnt_next = 16'h0000;
				end
			end
			ST_CONV: begin
				// Sampling stops here; the phase length ignores the attenuator
				strobe_next = cnt_reg == 16'h0000;
				cnt_next = cnt_reg + 16'h0001;
				if (cnt_reg >= 16'(goc_pkg::CONV_CYC - 1)) begin
					if (ctrl_reg[goc_pkg::CTRL_CHOP_BIT]) begin
						first_next = signedCode;
						invOut_next = !invOut_reg;
						state_next = attnOn ? ST_SETTLE : ST_CONV;
						cnt_next = 16'h0000;
					end else begin
						result_next = signedCode;
						ctrl_next[goc_pkg::CTRL_TRIG_BIT] = 1'b0;
						dlyRun_next = 1'b0;
						state_next = ST_IDLE;
					end
				end
			end
			ST_CHOP: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (state_reg == ST_CONV && cnt_reg >= 16'(goc_pkg::CONV_CYC - 1)
			&& ctrl_reg[goc_pkg::CTRL_CHOP_BIT] && invOut_reg != ctrl_reg[goc_pkg::CTRL_SIGN_BIT]) begin
			result_next = chopSum[10:1];
			ctrl_next[goc_pkg::CTRL_TRIG_BIT] = 1'b0;
			dlyRun_next = 1'b0;
			invOut_next = ctrl_reg[goc_pkg::CTRL_SIGN_BIT];
			state_next = ST_IDLE;
		end
	end

	// Delayed control outputs
	always_comb begin
		regOut_next = ctrl_reg[goc_pkg::CTRL_REG_EN_BIT];
		sampOut_next = ctrl_reg[goc_pkg::CTRL_SAMPLE_BIT] && state_reg != ST_CONV;
		if (ctrl2_reg[goc_pkg::CTRL2_DELAY_EN_BIT]) begin
			regOut_next = regOut_next
				&& dly_reg >= 12'(delay1_reg[7:0]) * 12'(goc_pkg::DELAY_STEP_CYC);
			sampOut_next = sampOut_next
				&& dly_reg >= 12'(delay2_reg) * 12'(goc_pkg::DELAY_STEP_CYC);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_reg <= goc_pkg::CTRL_RST;
			ctrl2_reg <= goc_pkg::CTRL2_RST[1:0];
			trimP_reg <= goc_pkg::TRIM_RST;
			trimN_reg <= goc_pkg::TRIM_RST;
			result_reg <= goc_pkg::MID_HIGH;
			delay1_reg <= goc_pkg::DELAY1_RST;
			delay2_reg <= goc_pkg::DELAY2_RST;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			bValid_reg <= 1'b0;
			bResp_reg <= goc_pkg::RESP_OKAY;
			rValid_reg <= 1'b0;
			rResp_reg <= goc_pkg::RESP_OKAY;
			rData_reg <= 32'h0000_0000;
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			dly_reg <= 12'h000;
			dlyRun_reg <= 1'b0;
			first_reg <= goc_pkg::MID_LOW;
			lastChan_reg <= 3'h0;
			strobe_reg <= 1'b0;
			regOut_reg <= 1'b0;
			sampOut_reg <= 1'b0;
			invOut_reg <= 1'b0;
			attn_reg <= 1'b0;
			awReady_reg <= 1'b1;
			wReady_reg <= 1'b1;
			arReady_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			ctrl2_reg <= ctrl2_next;
			trimP_reg <= trimP_next;
			trimN_reg <= trimN_next;
			result_reg <= result_next;
			delay1_reg <= delay1_next;
			delay2_reg <= delay2_next;
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			awAddr_reg <= awAddr_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			rValid_reg <= rValid_next;
			rResp_reg <= rResp_next;
			rData_reg <= rData_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			dly_reg <= dly_next;
			dlyRun_reg <= dlyRun_next;
			first_reg <= first_next;
			lastChan_reg <= lastChan_next;
			strobe_reg <= strobe_next;
			regOut_reg <= regOut_next;
			sampOut_reg <= sampOut_next;
			invOut_reg <= invOut_next;
			attn_reg <= attn_next;
			awReady_reg <= awReady_next;
			wReady_reg <= wReady_next;
			arReady_reg <= arReady_next;
		end
	end

	assign s_axi_awready = awReady_reg;
	assign s_axi_wready = wReady_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = arReady_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rresp = rResp_reg;
	assign s_axi_rdata = rData_reg;
	assign regulatorEnable = regOut_reg;
	assign samplingEnable = sampOut_reg;
	assign convertStrobe = strobe_reg;
	assign inputCenterMute = ctrl_reg[goc_pkg::CTRL_MUTE_BIT];
	assign polarityInvert = invOut_reg;
	assign tripleRangeAttenuator = attn_reg;
	assign singleEndedSelect = ctrl_reg[goc_pkg::CTRL_SE_BIT];
	assign channelSelect = ctrl_reg[goc_pkg::CTRL_CHAN_LSB +: goc_pkg::CTRL_CHAN_W];
	assign positiveOffsetTrim = trimP_reg;
	assign negativeOffsetTrim = trimN_reg;
endmodule

// ### verification/goc_converter_control_chk.sv
`timescale 1ns/1ps
module goc_converter_control_chk (
	input wire logic clock,
	input wire logic reset,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic samplingEnable,
	input wire logic convertStrobe,
	input wire logic tripleRangeAttenuator,
	input wire logic [2:0] channelSelect,
	input wire logic [9:0] positiveOffsetTrim,
	input wire logic [9:0] negativeOffsetTrim
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bHold: assert property (p_bHold) else $error("bvalid dropped before bready");
	property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read answer changed before rready");
	property p_badRead;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18 |=>
			s_axi_rvalid && s_axi_rresp == goc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_badRead: assert property (p_badRead) else $error("unmapped read not refused");
	property p_strobe; convertStrobe |=> !convertStrobe; endproperty
	a_strobe: assert property (p_strobe) else $error("convert strobe longer than one cycle");
	property p_noSample; convertStrobe |=> !samplingEnable; endproperty
	a_noSample: assert property (p_noSample) else $error("sampling during conversion");
	property p_battery; channelSelect == goc_pkg::CHAN_BATTERY |-> tripleRangeAttenuator;
	endproperty
	a_battery: assert property (p_battery) else $error("battery without attenuator");
	property p_settle;
		$changed(channelSelect) && tripleRangeAttenuator |-> !convertStrobe [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("conversion before settling");
	property p_trim;
		$changed(positiveOffsetTrim) || $changed(negativeOffsetTrim) |-> $rose(s_axi_bvalid);
	endproperty
	a_trim: assert property (p_trim) else $error("trim changed without write");
	c_strobe: cover property (convertStrobe);
	c_badRead: cover property (s_axi_rvalid && s_axi_rresp == goc_pkg::RESP_SLVERR);
	c_battery: cover property (convertStrobe && tripleRangeAttenuator);
endmodule
bind goc_converter_control goc_converter_control_chk i_chk (.clock(clock), .reset(reset),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.samplingEnable(samplingEnable), .convertStrobe(convertStrobe),
	.tripleRangeAttenuator(tripleRangeAttenuator), .channelSelect(channelSelect),
	.positiveOffsetTrim(positiveOffsetTrim), .negativeOffsetTrim(negativeOffsetTrim));

// ### verification/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
	logic clock = 0, reset = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdLast, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, regulatorEnable, samplingEnable, convertStrobe, inputCenterMute;
	logic polarityInvert, tripleRangeAttenuator, singleEndedSelect;
	logic [1:0] s_axi_bresp, s_axi_rresp, be;
	logic [2:0] channelSelect;
	logic [9:0] rawCode = 10'h203, positiveOffsetTrim, negativeOffsetTrim;
	logic [9:0] offP, offN, tn;
	logic [65:0] re;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	int failures = 0, nCompared = 0, cnt;
	integer seed = 32'he196;
	localparam logic [9:0] CM_BASE = 10'h200;
	// Regulator settling, 20 us
	localparam int REG_SETTLE_CYC = 20000 / goc_pkg::CLK_NS;
	goc_converter_control i_dut (.clock(clock), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rawCode(rawCode), .regulatorEnable(regulatorEnable),
		.samplingEnable(samplingEnable), .convertStrobe(convertStrobe),
		.inputCenterMute(inputCenterMute), .polarityInvert(polarityInvert),
		.tripleRangeAttenuator(tripleRangeAttenuator), .singleEndedSelect(singleEndedSelect),
		.channelSelect(channelSelect), .positiveOffsetTrim(positiveOffsetTrim),
		.negativeOffsetTrim(negativeOffsetTrim));
	initial begin
		forever #12.5 clock = ~clock;
	end
	// Checked at the falling edge, so the handshake edge values are settled
	always @(negedge clock) begin
		if (s_axi_bvalid && s_axi_bready) begin
			be = bq.pop_front();
			`CHK("bresp", be, s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			re = rq.pop_front();
			if (re[65:34] != 0) `CHK("rdata", re[33:2], s_axi_rdata & re[65:34])
			`CHK("rresp", re[1:0], s_axi_rresp)
		end
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, da, dw;
		da = 0;
		dw = 0;
		bq.push_back(r);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(da && dw)) begin
			@(negedge clock);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge clock);
			if (ta) begin
				s_axi_awvalid <= 0;
				da = 1;
			end
			if (tw) begin
				s_axi_wvalid <= 0;
				dw = 1;
			end
		end
		do @(negedge clock); while (!s_axi_bvalid);
		@(posedge clock);
		s_axi_bready <= 0;
	endtask
	// Mask of zero reads without a data comparison
	task automatic axr(input logic [7:0] a, input logic [31:0] m, d, input logic [1:0] r);
		rq.push_back({m, d & m, r});
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge clock); while (!s_axi_arready);
		@(posedge clock);
		s_axi_arvalid <= 0;
		do @(negedge clock); while (!s_axi_rvalid);
		rdLast = s_axi_rdata;
		@(posedge clock);
		s_axi_rready <= 0;
	endtask
	task automatic waitDone(input logic [9:0] e);
		do axr(goc_pkg::CTRL_OFS, 32'h0, 32'h0, goc_pkg::RESP_OKAY); while (rdLast[1]);
		axr(goc_pkg::RESULT_OFS, 32'h3ff, {22'h0, e}, goc_pkg::RESP_OKAY);
	endtask
	task automatic conv(input logic [31:0] c, input logic [9:0] e);
		axw(goc_pkg::CTRL_OFS, c | 32'h2, goc_pkg::RESP_OKAY);
		waitDone(e);
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge clock);
		reset <= 0;
		axr(goc_pkg::TRIMP_OFS, 32'h3ff, 32'h200, goc_pkg::RESP_OKAY);
		axr(goc_pkg::TRIMN_OFS, 32'h3ff, 32'h200, goc_pkg::RESP_OKAY);
		axr(goc_pkg::RESULT_OFS, 32'h3ff, 32'h200, goc_pkg::RESP_OKAY);
		axr(goc_pkg::DELAY1_OFS, 32'hffff, 32'h1000, goc_pkg::RESP_OKAY);
		axr(goc_pkg::DELAY2_OFS, 32'hff, 32'h08, goc_pkg::RESP_OKAY);
		axr(8'h40, 32'hffffffff, 32'h0, goc_pkg::RESP_SLVERR);
		axw(goc_pkg::RESULT_OFS, 32'h155, goc_pkg::RESP_SLVERR);
		axr(goc_pkg::RESULT_OFS, 32'h3ff, 32'h200, goc_pkg::RESP_OKAY);
		$display("Reset values and refusals done");
		axw(goc_pkg::CTRL_OFS, 32'h4, goc_pkg::RESP_OKAY);
		repeat (REG_SETTLE_CYC) @(posedge clock);
		`CHK("regulatorEnable", 1'b1, regulatorEnable)
		conv(32'h15, 10'h203);
		offP = rdLast[9:0] - CM_BASE;
		`CHK("inputCenterMute", 1'b1, inputCenterMute)
		`CHK("samplingEnable", 1'b1, samplingEnable)
		conv(32'h35, 10'h1fc);
		offN = rdLast[9:0] - CM_BASE;
		`CHK("polarityInvert", 1'b1, polarityInvert)
		axw(goc_pkg::TRIMP_OFS, {22'h0, CM_BASE - offP}, goc_pkg::RESP_OKAY);
		axw(goc_pkg::TRIMN_OFS, {22'h0, CM_BASE - offN}, goc_pkg::RESP_OKAY);
		`CHK("positiveOffsetTrim", 10'h1fd, positiveOffsetTrim)
		`CHK("negativeOffsetTrim", 10'h204, negativeOffsetTrim)
		conv(32'h15, 10'h203);
		conv(32'h55, 10'h1ff);
		$display("Mute, polarity and chop done");
		repeat (4) begin
			v = $random(seed);
			// Trim kept within 32 LSB of base; the unchopped result is rawCode itself
			tn = 10'h1e0 + {4'h0, v[15:10]};
			@(posedge clock);
			rawCode <= v[9:0];
			axw(goc_pkg::TRIMN_OFS, {22'h0, tn}, goc_pkg::RESP_OKAY);
			`CHK("negativeOffsetTrim", tn, negativeOffsetTrim)
			conv({28'h0, v[20], 3'h5}, v[9:0]);
			`CHK("singleEndedSelect", v[20], singleEndedSelect)
		end
		$display("Random conversions done");
		@(posedge clock);
		rawCode <= 10'h2a5;
		axw(goc_pkg::CTRL_OFS, 32'h407, goc_pkg::RESP_OKAY);
		cnt = 0;
		while (!convertStrobe) begin
			@(negedge clock);
			cnt++;
		end
		`CHK("tripleRangeAttenuator", 1'b1, tripleRangeAttenuator)
		`CHK("channelSelect", 3'h4, channelSelect)
		`CHK("settle", 1'b1, cnt >= goc_pkg::SETTLE_CYC)
		waitDone(10'h2a5);
		$display("Battery settling done");
		axw(goc_pkg::DELAY1_OFS, 32'h0200, goc_pkg::RESP_OKAY);
		axw(goc_pkg::CTRL2_OFS, 32'h2, goc_pkg::RESP_OKAY);
		conv(32'h05, 10'h2a5);
		`CHK("samplingEnable", 1'b0, samplingEnable)
		`CHK("regulatorEnable", 1'b1, regulatorEnable)
		axw(goc_pkg::CTRL2_OFS, 32'h0, goc_pkg::RESP_OKAY);
		axr(goc_pkg::CTRL2_OFS, 32'h3, 32'h0, goc_pkg::RESP_OKAY);
		`CHK("samplingEnable", 1'b1, samplingEnable)
		$display("Delay counter done");
		end_of_test;
	end
endmodule
